// ---- gsr_host.sv ----
/*
 * gsr_host: host serial master, mode 0, 32-bit frames, 320 ns sclk.
 * Assumes the caller enters xfer just after a system clock edge.
 */
`timescale 1ns/100ps
module gsr_host (
    input wire logic clk_sys_i,
    input wire logic miso_i,
    output logic sclk_o,
    output logic cs_n_o,
    output logic mosi_o
);
    // sclk stands still low outside frames
    initial begin
        sclk_o = 1'b0;
        cs_n_o = 1'b1;
        mosi_o = 1'b0;
    end

    // miso read just before the fall, where it is surely settled
    task automatic xfer(input logic [31:0] cmd, output logic [31:0] rsp);
        rsp = 32'h00000000;
        cs_n_o <= 1'b0;
        for (int i = 31; i >= 0; i--) begin
            mosi_o <= cmd[i];
            repeat (4) @(posedge clk_sys_i);
            sclk_o <= 1'b1;
            repeat (4) @(posedge clk_sys_i);
            rsp[i] = miso_i;
            sclk_o <= 1'b0;
        end
        repeat (4) @(posedge clk_sys_i);
        cs_n_o <= 1'b1;
        mosi_o <= ~mosi_o; // released data line, no stale level
        repeat (6) @(posedge clk_sys_i);
    endtask
endmodule

// ---- gsr_pkg.sv ----
/*
 * gsr_pkg: shared constants of the angular rate sensor register map:
 * register offsets, fault flag positions, serial frame layout, refresh
 * divisors and timing figures.
 * Assumes a 25 MHz system clock and a serial frame of 32 bits.
 */
package gsr_pkg;
    // system clock and fault set-up time
    localparam int unsigned CLK_PERIOD_NS = 40;
    localparam int unsigned FAULT_SET_MAX_NS = 5000;
    // longest time rounds down
    localparam int unsigned FAULT_SET_MAX_CYC = FAULT_SET_MAX_NS / CLK_PERIOD_NS;
    // sync stages plus the latch flop
    localparam int unsigned FAULT_PATH_CYC = 3;

    // register offsets (byte registers, read in pairs)
    localparam logic [7:0] ADDR_RATE_H = 8'h00;
    localparam logic [7:0] ADDR_RATE_L = 8'h01;
    localparam logic [7:0] ADDR_TEMP_H = 8'h02;
    localparam logic [7:0] ADDR_TEMP_L = 8'h03;
    localparam logic [7:0] ADDR_STF_H = 8'h04;
    localparam logic [7:0] ADDR_STF_L = 8'h05;
    localparam logic [7:0] ADDR_STR_H = 8'h06;
    localparam logic [7:0] ADDR_STR_L = 8'h07;
    localparam logic [7:0] ADDR_MOT_H = 8'h08;
    localparam logic [7:0] ADDR_MOT_L = 8'h09;
    localparam logic [7:0] ADDR_ERR_H = 8'h0A;
    localparam logic [7:0] ADDR_ERR_L = 8'h0B;
    localparam logic [7:0] ADDR_PART_H = 8'h0C;
    localparam logic [7:0] ADDR_PART_L = 8'h0D;
    localparam logic [7:0] ADDR_SN_3 = 8'h0E;
    localparam logic [7:0] ADDR_SN_2 = 8'h0F;
    localparam logic [7:0] ADDR_SN_1 = 8'h10;
    localparam logic [7:0] ADDR_SN_0 = 8'h11;

    // fault flag vector positions
    localparam int unsigned FLAG_N = 11;
    localparam int unsigned FLG_CHECK = 0;
    localparam int unsigned FLG_SELFTEST = 1;
    localparam int unsigned FLG_LOW_MSB = 6;
    localparam int unsigned FLG_HIGH_LSB = 7;
    localparam int unsigned FLG_HIGH_MSB = 10;
    localparam int unsigned EXT_FAULT_N = 10;

    // temperature field: 10 bits in the top of the pair
    localparam int unsigned TEMP_W = 10;
    localparam logic [5:0] TEMP_PAD = 6'h00;

    // refresh divisors of the resonator tick
    localparam int unsigned DIV_RATE = 32;
    localparam int unsigned DIV_SELFTEST = 16;
    localparam int unsigned DIV_MOTION = 64;
    localparam int unsigned RES_CNT_W = 6;

    // serial frame layout
    localparam int unsigned FRAME_BITS = 32;
    localparam int unsigned BIT_CNT_W = 6;
    localparam int unsigned OP_MSB = 31;
    localparam int unsigned OP_LSB = 30;
    localparam int unsigned ADR_MSB = 29;
    localparam int unsigned ADR_LSB = 22;
    localparam logic [1:0] OP_SENSOR = 2'h0;
    localparam logic [1:0] OP_WRITE = 2'h1;
    localparam logic [1:0] OP_READ = 2'h2;
    localparam logic [7:0] TAG_SENSOR = 8'hFF;
    localparam logic [7:0] BYTE_ZERO = 8'h00;
    localparam logic [31:0] RSP_IDLE = 32'h00000000;
endpackage

// ---- gsr_regmap.sv ----
/*
 * gsr_regmap: read-only register map of an angular rate sensor behind
 * a four-wire serial port, with latched fault flags.
 * Assumes the front end delivers filtered samples and one pulse per
 * resonator cycle on the system clock; fault conditions and serial pins
 * may be asynchronous.
 */
`timescale 1ns/100ps
module gsr_regmap #(
    parameter logic [7:0] PART_ID_HIGH = 8'hA5, // arbitrary value
    parameter logic [7:0] PART_REVISION = 8'h07, // arbitrary value
    parameter logic [31:0] SERIAL_NUMBER = 32'h1234ABCD, // arbitrary
    parameter logic signed [15:0] ST_LIMIT_LO = 16'sh0100,
    parameter logic signed [15:0] ST_LIMIT_HI = 16'sh7000
) (
    input wire logic clk_sys_i,
    input wire logic arst_n_i,
    // front end samples, same clock domain
    input wire logic res_tick_i,
    input wire logic [15:0] rate_i,
    input wire logic [gsr_pkg::TEMP_W-1:0] temp_i,
    input wire logic [15:0] selftest_filtered_i,
    input wire logic [15:0] selftest_raw_i,
    input wire logic [15:0] motion_error_i,
    // on-chip fault conditions, asynchronous levels
    input wire logic [gsr_pkg::EXT_FAULT_N-1:0] ext_fault_i,
    // serial port pins
    input wire logic spi_sclk_i,
    input wire logic spi_cs_n_i,
    input wire logic spi_mosi_i,
    output logic spi_miso_o,
    output logic spi_miso_oe_o
);
    import gsr_pkg::*;

    logic [2:0] pin_sync;
    logic [EXT_FAULT_N-1:0] fault_sync;
    logic sclk_s, cs_n_s, mosi_s;
    logic sclk_q_reg, cs_n_q_reg;
    logic sclk_rise, sclk_fall, cs_rise, cs_fall;
    logic [FRAME_BITS-1:0] rx_reg, tx_reg, tx_next;
    logic [BIT_CNT_W-1:0] bit_cnt_reg;
    logic [RES_CNT_W-1:0] res_cnt_reg;
    logic [15:0] rate_reg, temp_reg, stf_reg, str_reg, mot_reg;
    logic [FLAG_N-1:0] flags_reg, fault_cond;
    logic st_out_of_range;
    logic frame_ok, cmd_sensor, cmd_read, clear_flags;
    logic [1:0] opcode;
    logic [7:0] rd_addr;
    logic miso_oe_reg;

    // elaboration checks
    if (FAULT_PATH_CYC > FAULT_SET_MAX_CYC) begin : g_bad_timing
        $error("fault path slower than fault set-up limit");
    end
    if (ST_LIMIT_LO >= ST_LIMIT_HI) begin : g_bad_limits
        $error("self-test limits are not ordered");
    end
    // the condition vector below is wired by hand from these positions
    if (FLAG_N != EXT_FAULT_N + 1) begin : g_bad_flags
        $error("flag vector must hold every outside fault plus self-test");
    end
    if (FLG_SELFTEST != FLG_CHECK + 1) begin : g_bad_flag_order
        $error("self-test flag must sit just above the check flag");
    end
    if (FLG_LOW_MSB + 1 != FLG_HIGH_LSB) begin : g_bad_gap
        $error("fault bytes must split the flags without a gap");
    end
    if (FLG_HIGH_MSB != FLAG_N - 1) begin : g_bad_high_byte
        $error("upper fault byte must end at the top flag");
    end
    if (TEMP_W + $bits(TEMP_PAD) != 16) begin : g_bad_temp
        $error("temperature field and padding must fill one pair");
    end
    // counters must reach the longest group they count
    if ((1 << RES_CNT_W) < DIV_MOTION) begin : g_bad_divider
        $error("resonator counter too narrow for the slowest refresh");
    end
    if ((1 << BIT_CNT_W) <= FRAME_BITS) begin : g_bad_bit_count
        $error("bit counter cannot hold a full frame");
    end
    // the wrap test masks the counter, so divisors must be powers of two
    if (((DIV_RATE & (DIV_RATE - 1)) | (DIV_SELFTEST & (DIV_SELFTEST - 1)) |
         (DIV_MOTION & (DIV_MOTION - 1))) != 0) begin : g_bad_divisor
        $error("refresh divisors must be powers of two");
    end
    if (ADR_MSB - ADR_LSB != 7) begin : g_bad_addr
        $error("address field must be eight bits wide");
    end
    if (OP_MSB != FRAME_BITS - 1) begin : g_bad_op
        $error("opcode must lead the frame");
    end

    // every outside level passes two flops before use
    gsr_sync #(
        .WIDTH(3)
    ) u_pin_sync (
        .clk_sys_i(clk_sys_i),
        .arst_n_i(arst_n_i),
        .async_i({spi_sclk_i, ~spi_cs_n_i, spi_mosi_i}),
        .sync_o(pin_sync)
    );

    gsr_sync #(
        .WIDTH(EXT_FAULT_N)
    ) u_fault_sync (
        .clk_sys_i(clk_sys_i),
        .arst_n_i(arst_n_i),
        .async_i(ext_fault_i),
        .sync_o(fault_sync)
    );

    // select is carried inverted so that a cleared synchroniser reads as
    // deselected; a cleared low select would fake a frame edge and drive
    // the data pin for two cycles after every reset
    assign sclk_s = pin_sync[2];
    assign cs_n_s = ~pin_sync[1]; // stored active high
    assign mosi_s = pin_sync[0];

    // byte of the map at one address; unmapped reads give zero
    // odd or out-of-map addresses are not refused, they just see
    // whatever byte lies there, so a misaligned host gets shifted data
    function automatic logic [7:0] map_byte(input logic [7:0] addr,
                                            input logic [FLAG_N-1:0] flg);
        logic [7:0] b;
        b = BYTE_ZERO;
        unique case (addr)
            ADDR_RATE_H: b = rate_reg[15:8];
            ADDR_RATE_L: b = rate_reg[7:0];
            ADDR_TEMP_H: b = temp_reg[15:8];
            ADDR_TEMP_L: b = temp_reg[7:0];
            ADDR_STF_H: b = stf_reg[15:8];
            ADDR_STF_L: b = stf_reg[7:0];
            ADDR_STR_H: b = str_reg[15:8];
            ADDR_STR_L: b = str_reg[7:0];
            ADDR_MOT_H: b = mot_reg[15:8];
            ADDR_MOT_L: b = mot_reg[7:0];
            // upper nibble reads zero
            ADDR_ERR_H: b = {4'h0, flg[FLG_HIGH_MSB:FLG_HIGH_LSB]};
            // bit 0 always zero
            ADDR_ERR_L: b = {flg[FLG_LOW_MSB:0], 1'b0};
            ADDR_PART_H: b = PART_ID_HIGH;
            ADDR_PART_L: b = PART_REVISION;
            ADDR_SN_3: b = SERIAL_NUMBER[31:24];
            ADDR_SN_2: b = SERIAL_NUMBER[23:16];
            ADDR_SN_1: b = SERIAL_NUMBER[15:8];
            ADDR_SN_0: b = SERIAL_NUMBER[7:0];
            default: b = BYTE_ZERO;
        endcase
        return b;
    endfunction

    // true when an address touches a fault byte
    // a pair read from the byte below also lands on a fault byte
    function automatic logic is_fault_addr(input logic [7:0] addr);
        return (addr == ADDR_ERR_H) || (addr == ADDR_ERR_L);
    endfunction

    // true when the resonator counter wraps at the given divisor
    // fires on the last tick of each group, when the low bits are all ones
    function automatic logic div_hit(input logic [RES_CNT_W-1:0] cnt,
                                     input int unsigned div);
        logic [RES_CNT_W-1:0] mask;
        mask = RES_CNT_W'(div - 1);
        return (cnt & mask) == mask;
    endfunction

    // edge detection on the synchronised pins only
    // the previous-value flops reset to the idle levels, clock low and
    // deselected, so leaving reset never looks like an edge
    always_ff @(posedge clk_sys_i or negedge arst_n_i) begin
        if (!arst_n_i) begin
            sclk_q_reg <= 1'b0;
            cs_n_q_reg <= 1'b1;
        end else begin
            sclk_q_reg <= sclk_s;
            cs_n_q_reg <= cs_n_s;
        end
    end

    assign sclk_rise = sclk_s & ~sclk_q_reg & ~cs_n_s;
    assign sclk_fall = ~sclk_s & sclk_q_reg & ~cs_n_s;
    assign cs_fall = ~cs_n_s & cs_n_q_reg;
    assign cs_rise = cs_n_s & ~cs_n_q_reg;

    // resonator tick counter shared by all refresh dividers
    // one counter keeps the refreshes in step: every slow refresh lands
    // on the same tick as a fast one, never in between
    always_ff @(posedge clk_sys_i or negedge arst_n_i) begin
        if (!arst_n_i) begin
            res_cnt_reg <= '0;
        end else if (res_tick_i) begin
            res_cnt_reg <= res_cnt_reg + RES_CNT_W'(1);
        end
    end

    // rate and temperature snapshot every 32 resonator cycles
    // both taken on one tick so a pair read never mixes two samples
    always_ff @(posedge clk_sys_i or negedge arst_n_i) begin
        if (!arst_n_i) begin
            rate_reg <= 16'h0000;
            temp_reg <= 16'h0000;
        end else if (res_tick_i && div_hit(res_cnt_reg, DIV_RATE)) begin
            rate_reg <= rate_i;
            temp_reg <= {temp_i, TEMP_PAD};
        end
    end

    // both self-test pairs refresh every 16 resonator cycles
    // taken together so the host can hold raw against filtered
    always_ff @(posedge clk_sys_i or negedge arst_n_i) begin
        if (!arst_n_i) begin
            stf_reg <= 16'h0000;
            str_reg <= 16'h0000;
        end else if (res_tick_i && div_hit(res_cnt_reg, DIV_SELFTEST)) begin
            stf_reg <= selftest_filtered_i;
            str_reg <= selftest_raw_i;
        end
    end

    // motion error pair every 64 resonator cycles
    always_ff @(posedge clk_sys_i or negedge arst_n_i) begin
        if (!arst_n_i) begin
            mot_reg <= 16'h0000;
        end else if (res_tick_i && div_hit(res_cnt_reg, DIV_MOTION)) begin
            mot_reg <= motion_error_i;
        end
    end

    // only the filtered value is judged, the raw one cannot trip
    // judged on the held snapshot, so the flag can only rise at a refresh or after reset
    assign st_out_of_range = ($signed(stf_reg) < ST_LIMIT_LO) ||
                             ($signed(stf_reg) > ST_LIMIT_HI);

    // condition vector in flag order; self-test comes from the compare
    assign fault_cond = {fault_sync[EXT_FAULT_N-1:1], st_out_of_range,
                         fault_sync[FLG_CHECK]};

    // receive shift: sample on rising serial clock, MSB first
    // the count saturates at a full frame, so a longer frame keeps its
    // last 32 bits; a frame cut short never reaches 32 and is dropped
    always_ff @(posedge clk_sys_i or negedge arst_n_i) begin
        if (!arst_n_i) begin
            rx_reg <= '0;
            bit_cnt_reg <= '0;
        end else if (cs_fall) begin
            bit_cnt_reg <= '0;
        end else if (sclk_rise) begin
            rx_reg <= {rx_reg[FRAME_BITS-2:0], mosi_s};
            if (bit_cnt_reg != BIT_CNT_W'(FRAME_BITS)) begin
                bit_cnt_reg <= bit_cnt_reg + BIT_CNT_W'(1);
            end
        end
    end

    // a command counts only when the frame held at least 32 clocks
    // decoding waits for the select to rise, so a cut frame changes nothing
    assign frame_ok = cs_rise && (bit_cnt_reg == BIT_CNT_W'(FRAME_BITS));
    assign opcode = rx_reg[OP_MSB:OP_LSB];
    assign rd_addr = rx_reg[ADR_MSB:ADR_LSB];
    assign cmd_sensor = frame_ok && (opcode == OP_SENSOR);
    // writes and the spare code change no register; they only load the idle response
    assign cmd_read = frame_ok && (opcode == OP_READ);

    // clear on a read touching a fault byte or on a sensor request
    assign clear_flags = cmd_sensor ||
        (cmd_read && (is_fault_addr(rd_addr) ||
                      is_fault_addr(rd_addr + 8'h01)));

    // latched flags; a live condition wins over the clear
    // two sync flops plus this one make three clocks from pin to flag,
    // far inside the five microsecond limit at the system clock rate
    always_ff @(posedge clk_sys_i or negedge arst_n_i) begin
        if (!arst_n_i) begin
            flags_reg <= '0;
        end else begin
            flags_reg <= (flags_reg & ~{FLAG_N{clear_flags}}) | fault_cond;
        end
    end

    // response to the command, built from state before any clear
    always_comb begin
        tx_next = tx_reg;
        if (cmd_read) begin
            // addressed byte high, next byte appended low
            tx_next = {rd_addr, map_byte(rd_addr, flags_reg),
                       map_byte(rd_addr + 8'h01, flags_reg), BYTE_ZERO};
        end else if (cmd_sensor) begin
            // rate word plus the low fault byte
            tx_next = {TAG_SENSOR, rate_reg,
                       map_byte(ADDR_ERR_L, flags_reg)};
        end else if (frame_ok) begin
            tx_next = RSP_IDLE;
        end else if (sclk_fall) begin
            // next bit out on the falling serial clock
            tx_next = {tx_reg[FRAME_BITS-2:0], 1'b0};
        end
    end

    // transmit shift; the answer leaves during the following frame
    // the command is only known once its frame has ended, so answering
    // in the same frame would need the first bit before it is decided;
    // the cost is one extra frame per read
    always_ff @(posedge clk_sys_i or negedge arst_n_i) begin
        if (!arst_n_i) begin
            tx_reg <= RSP_IDLE;
        end else begin
            tx_reg <= tx_next;
        end
    end

    // drive the data pin only while selected
    // follows the synchronised select, so it trails the pin by three
    // clocks; the host must leave that long before its first clock edge
    always_ff @(posedge clk_sys_i or negedge arst_n_i) begin
        if (!arst_n_i) begin
            miso_oe_reg <= 1'b0;
        end else begin
            miso_oe_reg <= ~cs_n_s;
        end
    end

    // the pin always shows the top of the shifter; qualify with the enable
    assign spi_miso_o = tx_reg[FRAME_BITS-1];
    assign spi_miso_oe_o = miso_oe_reg;
endmodule

// ---- gsr_regmap_asserts.sv ----
/*
 * gsr_regmap_asserts: port checks of the serial pins of gsr_regmap.
 * Assumes pins are driven on the system clock, sclk idles low.
 */
`timescale 1ns/100ps
module gsr_regmap_asserts (
    input wire logic clk_sys_i,
    input wire logic arst_n_i,
    input wire logic spi_sclk_i,
    input wire logic spi_cs_n_i,
    input wire logic spi_miso_o,
    input wire logic spi_miso_oe_o
);
    logic [3:0] quiet_reg;

    default clocking @(posedge clk_sys_i);
    endclocking
    default disable iff (!arst_n_i);

    // cycles since an sclk fall or cs rise; miso may only move soon after
    always_ff @(posedge clk_sys_i or negedge arst_n_i) begin
        if (!arst_n_i) begin
            quiet_reg <= 4'hF;
        end else if ($fell(spi_sclk_i) || $rose(spi_cs_n_i)) begin
            quiet_reg <= 4'h0;
        end else if (quiet_reg != 4'hF) begin
            quiet_reg <= quiet_reg + 4'h1;
        end
    end

    a_reset_quiet: assert property ($rose(arst_n_i) |->
        (!spi_miso_o && !spi_miso_oe_o) [*3])
        else $error("miso busy right after reset");
    a_oe_on_select: assert property ($fell(spi_cs_n_i) |->
        ##[1:4] spi_miso_oe_o)
        else $error("miso not driven after select");
    a_oe_off_deselect: assert property ($rose(spi_cs_n_i) |->
        ##[1:4] !spi_miso_oe_o)
        else $error("miso still driven after deselect");
    a_oe_holds: assert property (!spi_cs_n_i [*5] |->
        spi_miso_oe_o)
        else $error("miso enable dropped inside frame");
    a_miso_quiet: assert property ($changed(spi_miso_o) |->
        quiet_reg <= 4'h6)
        else $error("miso moved without sclk fall");
    a_miso_idle: assert property (spi_cs_n_i [*7] |->
        $stable(spi_miso_o))
        else $error("response changed between frames");
    a_miso_sclk_high: assert property (spi_sclk_i [*3] |->
        $stable(spi_miso_o))
        else $error("miso moved while sclk high");
    a_first_bit: assert property ($fell(spi_cs_n_i) |->
        $stable(spi_miso_o) [*3])
        else $error("first response bit lost");
endmodule

bind gsr_regmap gsr_regmap_asserts chk_u (
    .clk_sys_i(clk_sys_i),
    .arst_n_i(arst_n_i),
    .spi_sclk_i(spi_sclk_i),
    .spi_cs_n_i(spi_cs_n_i),
    .spi_miso_o(spi_miso_o),
    .spi_miso_oe_o(spi_miso_oe_o)
);

// ---- gsr_regmap_tb.sv ----
/*
 * gsr_regmap_tb: self-checking bench of gsr_regmap through its pins.
 * Assumes gsr_host as the serial master; responses come a frame late.
 */
`timescale 1ns/100ps
module gsr_regmap_tb;
    import gsr_pkg::*;
    typedef struct packed {
        logic [31:0] cmd;
        logic [31:0] rsp;
    } gsr_row_s;
    localparam logic [15:0] RATE_V = 16'hFC18;
    localparam logic [15:0] STF_V = 16'h0800;
    localparam logic [15:0] STR_V = 16'h7F00;
    localparam logic [15:0] MOT_V = 16'h8001;
    localparam logic [7:0] PID_H = 8'h3C; // arbitrary value
    localparam logic [7:0] PID_R = 8'h09; // arbitrary value
    localparam logic [31:0] SN_V = 32'hC0DE1357; // arbitrary value
    localparam logic [31:0] FETCH = 32'hC0000000;
    logic clk_sys, arst_n, tick, sclk, cs_n, mosi, miso, miso_oe, miso_line;
    logic [9:0] temp, ext;
    logic [15:0] rate, stf, strw, mot;
    int miscompares = 0;
    int tests_run = 0;
    int cycles = 0;
    gsr_row_s rows [11];

    gsr_regmap #(.PART_ID_HIGH(PID_H), .PART_REVISION(PID_R),
        .SERIAL_NUMBER(SN_V)) dut_u (
        .clk_sys_i(clk_sys), .arst_n_i(arst_n), .res_tick_i(tick),
        .rate_i(rate), .temp_i(temp), .selftest_filtered_i(stf),
        .selftest_raw_i(strw), .motion_error_i(mot), .ext_fault_i(ext),
        .spi_sclk_i(sclk), .spi_cs_n_i(cs_n), .spi_mosi_i(mosi),
        .spi_miso_o(miso), .spi_miso_oe_o(miso_oe));
    gsr_host host_u (.clk_sys_i(clk_sys), .miso_i(miso_line),
        .sclk_o(sclk), .cs_n_o(cs_n), .mosi_o(mosi));
    // undriven line shows the inverse, never a tidy stale bit
    assign miso_line = miso_oe ? miso : ~miso;

    initial begin
        clk_sys = 1'b0;
        forever #20 clk_sys = ~clk_sys;
    end

    function automatic logic [31:0] mk(input logic [1:0] op,
                                       input logic [7:0] a);
        return {op, a, 22'h0};
    endfunction
    function automatic logic [31:0] rx(input logic [7:0] a,
                                       input logic [15:0] d);
        return {a, d, 8'h00};
    endfunction
    // fault pair as laid out in the two fault bytes
    function automatic logic [15:0] fw(input logic [9:0] e, input logic st);
        return {4'h0, e[9:6], e[5:1], st, e[0], 1'b0};
    endfunction

    task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
        tests_run++;
        if (seen !== exp) begin
            miscompares++;
            $display("mismatch at %0t: seen %h expected %h", $time, seen,
                exp);
        end
    endtask
    task automatic report_and_stop;
        $display("comparisons %0d, mismatches %0d", tests_run, miscompares);
        if (miscompares == 0 && tests_run > 0)
            $display("Testbench passed");
        else
            $display("Testbench failed");
        $finish;
    endtask
    // command frame, then a neutral frame that carries its answer out
    task automatic rd(input logic [31:0] c, output logic [31:0] r);
        logic [31:0] junk;
        host_u.xfer(c, junk);
        host_u.xfer(FETCH, r);
    endtask
    task automatic ticks(input int n);
        repeat (n) begin
            @(posedge clk_sys);
            tick <= 1'b1;
            @(posedge clk_sys);
            tick <= 1'b0;
        end
    endtask

    // a hang counts as a mismatch
    always @(posedge clk_sys) begin
        cycles++;
        if (cycles == 30000) begin
            miscompares++;
            report_and_stop();
        end
    end

    initial begin
        logic [31:0] r;
        {arst_n, tick, ext, temp} = '0;
        {rate, stf, strw, mot} = {RATE_V, STF_V, STR_V, MOT_V};
        temp = 10'h320;
        rows[0] = '{32'h403FFFFF, 32'h0};
        rows[1] = '{mk(OP_READ, ADDR_RATE_H), rx(8'h00, RATE_V)};
        rows[2] = '{mk(OP_READ, ADDR_TEMP_H), rx(8'h02, 16'hC800)};
        rows[3] = '{mk(OP_READ, ADDR_STF_H), rx(8'h04, STF_V)};
        rows[4] = '{mk(OP_READ, ADDR_STR_H), rx(8'h06, STR_V)};
        rows[5] = '{mk(OP_READ, ADDR_MOT_H), rx(8'h08, MOT_V)};
        rows[6] = '{mk(OP_READ, ADDR_PART_H),
            rx(8'h0C, {PID_H, PID_R})};
        rows[7] = '{mk(OP_READ, ADDR_SN_3), rx(8'h0E, SN_V[31:16])};
        rows[8] = '{mk(OP_READ, ADDR_SN_1), rx(8'h10, SN_V[15:0])};
        rows[9] = '{mk(OP_READ, 8'h12), rx(8'h12, 16'h0000)};
        rows[10] = '{mk(OP_SENSOR, 8'h00), {8'hFF, RATE_V, 8'h00}};
        repeat (10) @(posedge clk_sys);
        chk({30'h0, miso, miso_oe}, 32'h0);
        arst_n <= 1'b1;
        repeat (4) @(posedge clk_sys);
        ticks(31);
        rd(mk(OP_READ, ADDR_RATE_H), r);
        chk(r, rx(8'h00, 16'h0000));
        rd(mk(OP_READ, ADDR_STF_H), r);
        chk(r, rx(8'h04, STF_V));
        rd(mk(OP_READ, ADDR_MOT_H), r);
        chk(r, rx(8'h08, 16'h0000));
        ticks(33);
        // self-test value was zero, below limits, after reset; the flag stays latched
        rd(mk(OP_SENSOR, 8'h00), r);
        chk(r, {8'hFF, RATE_V, 8'h04});
        for (int i = 0; i < 11; i++) begin
            rd(rows[i].cmd, r);
            chk(r, rows[i].rsp);
        end
        // short fault pulse must still be latched
        ext <= 10'h2A5;
        repeat (FAULT_SET_MAX_CYC) @(posedge clk_sys);
        ext <= 10'h000;
        rd(mk(OP_READ, ADDR_ERR_H), r);
        chk(r, rx(8'h0A, fw(10'h2A5, 1'b0)));
        rd(mk(OP_READ, ADDR_ERR_H), r);
        chk(r, rx(8'h0A, 16'h0000));
        ext <= 10'h001;
        repeat (2) begin
            rd(mk(OP_READ, ADDR_ERR_H), r);
            chk(r, rx(8'h0A, fw(10'h001, 1'b0)));
        end
        ext <= 10'h040;
        repeat (8) @(posedge clk_sys);
        ext <= 10'h000;
        rd(mk(OP_SENSOR, 8'h00), r);
        chk(r, {8'hFF, RATE_V, 8'h02});
        rd(mk(OP_READ, ADDR_ERR_H), r);
        chk(r, rx(8'h0A, 16'h0000));
        // one below the lower limit
        stf <= 16'h00FF;
        ticks(16);
        rd(mk(OP_SENSOR, 8'h00), r);
        chk(r, {8'hFF, RATE_V, 8'h04});
        rd(mk(OP_READ, ADDR_ERR_L), r);
        chk(r, rx(8'h0B, {8'h04, PID_H}));
        // reset in mid-run: pins quiet, snapshots and flags start over
        arst_n <= 1'b0;
        repeat (2) @(posedge clk_sys);
        chk({30'h0, miso, miso_oe}, 32'h0);
        arst_n <= 1'b1;
        repeat (4) @(posedge clk_sys);
        rd(mk(OP_READ, ADDR_RATE_H), r);
        chk(r, rx(8'h00, 16'h0000));
        // cleared self-test snapshot lies below the limits again
        rd(mk(OP_READ, ADDR_ERR_H), r);
        chk(r, rx(8'h0A, 16'h0004));
        report_and_stop();
    end
endmodule

// ---- gsr_sync.sv ----
/*
 * gsr_sync: two flip-flop synchroniser for a bus of independent levels.
 * Assumes each bit is a level that may change at any time; no bus
 * coherence is given between bits.
 */
`timescale 1ns/100ps
module gsr_sync #(
    parameter int unsigned WIDTH = 1
) (
    input wire logic clk_sys_i,
    input wire logic arst_n_i,
    input wire logic [WIDTH-1:0] async_i,
    output logic [WIDTH-1:0] sync_o
);
    logic [WIDTH-1:0] meta_reg;

    // first stage is read only by the second
    always_ff @(posedge clk_sys_i or negedge arst_n_i) begin
        if (!arst_n_i) begin
            meta_reg <= '0;
            sync_o <= '0;
        end else begin
            meta_reg <= async_i;
            sync_o <= meta_reg;
        end
    end
endmodule
